/* File: common/emb_pkg.sv */
// Package of constants and types for the external memory strobe block
package emb_pkg;
  localparam int EMB_DATA_W = 16;
  localparam int EMB_ADDR_W = 24;
  localparam int EMB_NCS = 8;
  localparam int EMB_CS_PROG = 0;
  localparam int EMB_CS_DATA = 1;
  // Strobe low time of one cycle, in ns, and derived count
  localparam int EMB_STROBE_NS = 20;
  localparam int EMB_CLK_MHZ = 200;
  localparam int EMB_STROBE_CYC_RAW = (EMB_STROBE_NS * EMB_CLK_MHZ + 999) / 1000;
  localparam int EMB_STROBE_CYC = (EMB_STROBE_CYC_RAW < 1) ? 1 : EMB_STROBE_CYC_RAW;
  localparam logic EMB_KEEP_DRIVEN_RST = 1'b0;
  localparam logic EMB_CTRL_PU_DIS_RST = 1'b0;
  localparam logic [EMB_DATA_W-1:0] EMB_PORTF_PU_RST = 16'hffff;
  localparam logic [EMB_NCS-1:0] EMB_CS_IDLE = 8'hff;
  localparam logic [EMB_DATA_W-1:0] EMB_DATA_ZERO = 16'h0000;
  localparam logic [EMB_ADDR_W-1:0] EMB_ADDR_ZERO = 24'h000000;
  typedef enum logic [1:0] {
    EMB_SP_NONE,
    EMB_SP_PROG,
    EMB_SP_DATA
  } emb_space_t;
  typedef enum {
    EMB_IDLE,
    EMB_READ,
    EMB_WRITE
  } emb_state_t;
endpackage

/* File: common/emb_tmr_if.sv */
// Interface between the strobe sequencer and its cycle timer
`timescale 1ns/1ps
interface emb_tmr_if;
  logic start;
  logic done;
  modport ctrl (output start, input done);
  modport tmr (input start, output done);
endinterface

/* File: design/emb_strobes.sv */
// External memory port: strobes, selects, data direction and pull-ups
`timescale 1ns/1ps
// Overview of operation
// - Read strobe low during each read cycle
// - Data pins input while read strobe low
// - Capture read data on read strobe rise
// - Selects qualified by active strobe; address holds its last value
// - Write strobe low during each write cycle
// - Data pins driven while write strobe low
// - Keep-driven bit chooses drive or float when bus idle
// - Software should set keep-driven bit to one
// - Control pull-up bit disables strobe pull-ups
// - Program select low for program memory access
// - Chip select zero acts as program select
// - Cleared port F bit disables pin pull-up
// - Chip select one is data-memory select
module emb_strobes
  import emb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic i_we,
  input wire emb_space_t i_space,
  input wire logic [EMB_NCS-1:0] i_cs_sel,
  input wire logic [EMB_ADDR_W-1:0] i_addr,
  input wire logic [EMB_DATA_W-1:0] i_wdata,
  input wire logic i_bus_keep_driven_wr,
  input wire logic i_bus_keep_driven,
  input wire logic i_ctrl_pullup_dis_wr,
  input wire logic i_ctrl_pullup_dis,
  input wire logic i_portf_pullup_wr,
  input wire logic [EMB_DATA_W-1:0] i_portf_pullup,
  input wire logic [EMB_DATA_W-1:0] i_data_pins,
  output logic o_busy,
  output logic o_rvalid,
  output logic [EMB_DATA_W-1:0] o_rdata,
  output logic [EMB_ADDR_W-1:0] o_address_pins,
  output logic [EMB_DATA_W-1:0] o_data_pins,
  output logic o_data_pins_oe,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [EMB_NCS-1:0] o_chip_selects,
  output logic o_ctrl_oe,
  output logic o_strobe_pullup_en,
  output logic [EMB_DATA_W-1:0] o_portf_pullup_en,
  output logic o_bus_keep_driven
);
  // ****************************************
  // Configuration bits
  // ****************************************
  logic keep_q, keep_d;
  logic pudis_q, pudis_d;
  logic [EMB_DATA_W-1:0] pfpu_q, pfpu_d;

  always_comb begin
    keep_d = i_bus_keep_driven_wr ? i_bus_keep_driven : keep_q;
    pudis_d = i_ctrl_pullup_dis_wr ? i_ctrl_pullup_dis : pudis_q;
    pfpu_d = i_portf_pullup_wr ? i_portf_pullup : pfpu_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      keep_q <= EMB_KEEP_DRIVEN_RST;
      pudis_q <= EMB_CTRL_PU_DIS_RST;
      pfpu_q <= EMB_PORTF_PU_RST;
    end else begin
      keep_q <= keep_d;
      pudis_q <= pudis_d;
      pfpu_q <= pfpu_d;
    end
  end

  // ****************************************
  // Cycle sequencer
  // ****************************************
  emb_tmr_if tif ();
  emb_timer u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .tif(tif.tmr)
  );

  emb_state_t st_q, st_d;
  logic rd_n_q, rd_n_d, wr_n_q, wr_n_d, doe_q, doe_d, coe_q, coe_d, rv_q, rv_d, busy_q, busy_d;
  logic [EMB_NCS-1:0] cs_q, cs_d, sel;
  logic [EMB_ADDR_W-1:0] a_q, a_d;
  logic [EMB_DATA_W-1:0] wd_q, wd_d, rdat_q, rdat_d;

  always_comb begin
    sel = i_cs_sel;
    case (i_space)
      EMB_SP_PROG: sel[EMB_CS_PROG] = 1'b0;
      EMB_SP_DATA: sel[EMB_CS_DATA] = 1'b0;
      default: sel = i_cs_sel;
    endcase
  end

  always_comb begin
    st_d = st_q;
    rd_n_d = rd_n_q;
    wr_n_d = wr_n_q;
    doe_d = doe_q;
    cs_d = cs_q;
    a_d = a_q;
    wd_d = wd_q;
    rdat_d = rdat_q;
    rv_d = 1'b0;
    busy_d = busy_q;
    tif.start = 1'b0;
    case (st_q)
      EMB_IDLE: begin
        if (i_req) begin
          tif.start = 1'b1;
          busy_d = 1'b1;
          a_d = i_addr;
          cs_d = sel;
          if (i_we) begin
            st_d = EMB_WRITE;
            wr_n_d = 1'b0;
            doe_d = 1'b1;
            wd_d = i_wdata;
          end else begin
            st_d = EMB_READ;
            rd_n_d = 1'b0;
            doe_d = 1'b0;
          end
        end
      end
      EMB_READ: begin
        if (tif.done) begin
          st_d = EMB_IDLE;
          rd_n_d = 1'b1;
          rdat_d = i_data_pins;
          rv_d = 1'b1;
          cs_d = EMB_CS_IDLE;
          busy_d = 1'b0;
        end
      end
      EMB_WRITE: begin
        if (tif.done) begin
          st_d = EMB_IDLE;
          wr_n_d = 1'b1;
          cs_d = EMB_CS_IDLE;
          busy_d = 1'b0;
        end
      end
      default: begin
        st_d = EMB_IDLE;
        rd_n_d = 1'b1;
        wr_n_d = 1'b1;
        cs_d = EMB_CS_IDLE;
        busy_d = 1'b0;
      end
    endcase
    // Data keeps driving one cycle past write rise for hold
    if (st_q == EMB_IDLE && !i_req) begin
      doe_d = 1'b0;
    end
    coe_d = (st_d != EMB_IDLE) || keep_d;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= EMB_IDLE;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      doe_q <= 1'b0;
      coe_q <= 1'b0;
      cs_q <= EMB_CS_IDLE;
      a_q <= EMB_ADDR_ZERO;
      wd_q <= EMB_DATA_ZERO;
      rdat_q <= EMB_DATA_ZERO;
      rv_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      doe_q <= doe_d;
      coe_q <= coe_d;
      cs_q <= cs_d;
      a_q <= a_d;
      wd_q <= wd_d;
      rdat_q <= rdat_d;
      rv_q <= rv_d;
      busy_q <= busy_d;
    end
  end

  // ****************************************
  // Outputs and pull-ups
  // ****************************************
  logic supu_q;
  logic [EMB_DATA_W-1:0] pfen_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      supu_q <= 1'b1;
      pfen_q <= EMB_PORTF_PU_RST;
    end else begin
      supu_q <= !pudis_d;
      pfen_q <= pfpu_d;
    end
  end

  assign o_busy = busy_q;
  assign o_rvalid = rv_q;
  assign o_rdata = rdat_q;
  assign o_address_pins = a_q;
  assign o_data_pins = wd_q;
  assign o_data_pins_oe = doe_q;
  assign o_rd_n = rd_n_q;
  assign o_wr_n = wr_n_q;
  assign o_chip_selects = cs_q;
  assign o_ctrl_oe = coe_q;
  assign o_strobe_pullup_en = supu_q;
  assign o_portf_pullup_en = pfen_q;
  assign o_bus_keep_driven = keep_q;

  // ****************************************
  // Checks
  // ****************************************
  // Index of the last strobe low sample, counted from the first low sample
  localparam int RD_LAST = EMB_STROBE_CYC - 1;
  sequence s_rd_start;
    !o_rd_n && $past(o_rd_n);
  endsequence
  sequence s_wr_start;
    !o_wr_n && $past(o_wr_n);
  endsequence
  property p_rd_input;
    @(posedge i_clk) disable iff (i_rst) !o_rd_n |-> !o_data_pins_oe;
  endproperty
  a_rd_input: assert property (p_rd_input) else $error("data driven during read");
  property p_wr_drive;
    @(posedge i_clk) disable iff (i_rst) !o_wr_n |-> o_data_pins_oe;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("data not driven during write");
  property p_rd_width;
    @(posedge i_clk) disable iff (i_rst) s_rd_start |-> ##[RD_LAST:RD_LAST] !o_rd_n ##1 o_rd_n;
  endproperty
  a_rd_width: assert property (p_rd_width) else $error("read strobe width wrong");
  property p_wr_width;
    @(posedge i_clk) disable iff (i_rst) s_wr_start |-> ##[RD_LAST:RD_LAST] !o_wr_n ##1 o_wr_n;
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("write strobe width wrong");
  property p_capture;
    @(posedge i_clk) disable iff (i_rst) $rose(o_rd_n) |-> o_rvalid && o_rdata == $past(i_data_pins);
  endproperty
  a_capture: assert property (p_capture) else $error("read data not captured");
  property p_qualify;
    @(posedge i_clk) disable iff (i_rst) (o_chip_selects != EMB_CS_IDLE) |-> (!o_rd_n || !o_wr_n);
  endproperty
  a_qualify: assert property (p_qualify) else $error("select active without strobe");
  property p_exclusive;
    @(posedge i_clk) disable iff (i_rst) !(!o_rd_n && !o_wr_n);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("both strobes low");
  property p_float;
    @(posedge i_clk) disable iff (i_rst) (o_rd_n && o_wr_n && !o_bus_keep_driven) |-> !o_ctrl_oe;
  endproperty
  a_float: assert property (p_float) else $error("idle bus driven without keep bit");
  property p_keep;
    @(posedge i_clk) disable iff (i_rst) o_bus_keep_driven |-> o_ctrl_oe;
  endproperty
  a_keep: assert property (p_keep) else $error("keep bit set but bus floats");
  property p_ps;
    @(posedge i_clk) disable iff (i_rst) (i_req && !o_busy && i_space == EMB_SP_PROG)
      |=> !o_chip_selects[EMB_CS_PROG];
  endproperty
  a_ps: assert property (p_ps) else $error("program select not asserted");
  property p_pu;
    @(posedge i_clk) disable iff (i_rst) i_ctrl_pullup_dis_wr && i_ctrl_pullup_dis |=> !o_strobe_pullup_en;
  endproperty
  a_pu: assert property (p_pu) else $error("strobe pull-up not disabled");
endmodule

/* File: design/emb_timer.sv */
// Strobe width timer: counts the strobe low time
`timescale 1ns/1ps
module emb_timer
  import emb_pkg::*;
#(
  parameter int CYCLES = EMB_STROBE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  emb_tmr_if.tmr tif
);
  localparam int CW = (CYCLES < 2) ? 1 : $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic run_q, run_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    if (tif.start) begin
      cnt_d = '0;
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q == LAST) begin
        run_d = 1'b0;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

  assign tif.done = run_q && (cnt_q == LAST);
endmodule

/* File: test/emb_mem_model.sv */
// Behavioural static memory on the far side of the external memory port
`timescale 1ns/1ps
module emb_mem_model (
  input wire logic i_clk,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_cs,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq
);
  logic [15:0] mem_q [256];
  logic [15:0] last_q = 16'h0000;
  logic [7:0] wa_q = 8'h00;
  logic [15:0] wd_q = 16'h0000;
  wire sel = i_cs != 8'hff;
  // Released bus toggles so stale data cannot pass
  assign o_dq = (!i_rd_n && sel) ? mem_q[i_addr[7:0]] : ~last_q;
  always @(posedge i_clk) begin
    last_q <= o_dq;
    if (!i_wr_n && sel) begin
      wa_q <= i_addr[7:0];
      wd_q <= i_dq;
    end
  end
  always @(posedge i_wr_n) mem_q[wa_q] = wd_q;
endmodule

/* File: test/tb.sv */
// Self-checking testbench for the external memory strobe block
`timescale 1ns/1ps
module tb;
  import emb_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic req = 1'b0, we = 1'b0, kd_wr = 1'b0, kd = 1'b0, pd_wr = 1'b0, pd = 1'b0, pf_wr = 1'b0;
  emb_space_t sp = EMB_SP_NONE;
  logic [7:0] cs_sel = 8'hff;
  logic [23:0] addr = 24'h000000;
  logic [15:0] wd = 16'h0000, pf = 16'hffff, rd;
  logic busy, rv, d_oe, rd_n, wr_n, c_oe, s_pu, keep;
  logic [15:0] rdata, d_out, pf_en, mem_dq, bus;
  logic [23:0] a_out;
  logic [7:0] cs;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #2.5 i_clk = ~i_clk;
  assign bus = d_oe ? d_out : mem_dq;
  emb_strobes emb_strobes_i (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_we(we), .i_space(sp),
    .i_cs_sel(cs_sel), .i_addr(addr), .i_wdata(wd), .i_bus_keep_driven_wr(kd_wr), .i_bus_keep_driven(kd),
    .i_ctrl_pullup_dis_wr(pd_wr), .i_ctrl_pullup_dis(pd), .i_portf_pullup_wr(pf_wr), .i_portf_pullup(pf),
    .i_data_pins(bus), .o_busy(busy), .o_rvalid(rv), .o_rdata(rdata), .o_address_pins(a_out),
    .o_data_pins(d_out), .o_data_pins_oe(d_oe), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_chip_selects(cs),
    .o_ctrl_oe(c_oe), .o_strobe_pullup_en(s_pu), .o_portf_pullup_en(pf_en), .o_bus_keep_driven(keep));
  emb_mem_model emb_mem_model_i (.i_clk(i_clk), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_cs(cs), .i_addr(a_out),
    .i_dq(bus), .o_dq(mem_dq));
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One access, judged at the pins; returns read data
  task automatic acc(input logic w, input emb_space_t s, input logic [23:0] a, input logic [15:0] d,
                     input logic [7:0] ecs);
    int n;
    @(negedge i_clk);
    req = 1'b1; we = w; sp = s; addr = a; wd = d;
    @(negedge i_clk);
    req = 1'b0;
    chk("rd_n", w, rd_n);
    chk("wr_n", !w, wr_n);
    chk("data_oe", w, d_oe);
    chk("cs", ecs, cs);
    chk("addr", a, a_out);
    chk("ctrl_oe", 1'b1, c_oe);
    if (w) chk("dout", d, d_out);
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    chk("width", EMB_STROBE_CYC, n);
    chk("cs_end", 8'hff, cs);
    if (!w) chk("rvalid", 1'b1, rv);
    rd = rdata;
  endtask
  task automatic rw(input emb_space_t s, input logic [23:0] a, input logic [15:0] d, input logic [7:0] ecs);
    acc(1'b1, s, a, d, ecs);
    acc(1'b0, s, a, 16'h0000, ecs);
    chk("rdata", d, rd);
  endtask
  // ***************
  // Scenarios
  // ***************
  task automatic t_reset();
    chk("rst_strobes", 2'b11, {rd_n, wr_n});
    chk("rst_cs", 8'hff, cs);
    chk("rst_oe", 2'b00, {c_oe, d_oe});
    chk("rst_pu", 17'h1ffff, {s_pu, pf_en});
  endtask
  task automatic t_spaces();
    rw(EMB_SP_PROG, 24'h000012, 16'ha5c3, 8'hfe);
    acc(1'b1, EMB_SP_DATA, 24'hff0021, 16'h3c5a, 8'hfd);
    acc(1'b1, EMB_SP_DATA, 24'hff0022, 16'h0ff0, 8'hfd);
    acc(1'b0, EMB_SP_DATA, 24'hff0021, 16'h0000, 8'hfd);
    chk("rdata", 16'h3c5a, rd);
    cs_sel = 8'hfb;
    rw(EMB_SP_NONE, 24'h800033, 16'hffff, 8'hfb);
    cs_sel = 8'hff;
  endtask
  task automatic t_keep();
    @(negedge i_clk);
    kd = 1'b1;
    kd_wr = 1'b1;
    @(negedge i_clk);
    kd_wr = 1'b0;
    @(negedge i_clk);
    chk("keep", 2'b11, {keep, c_oe});
    rw(EMB_SP_DATA, 24'h000044, 16'h1234, 8'hfd);
    repeat (2) @(negedge i_clk);
    chk("idle_drv", 11'h7ff, {c_oe, rd_n, wr_n, cs});
    kd = 1'b0;
    kd_wr = 1'b1;
    @(negedge i_clk);
    kd_wr = 1'b0;
    @(negedge i_clk);
    chk("float", 2'b00, {keep, c_oe});
  endtask
  task automatic t_pull();
    @(negedge i_clk);
    pd = 1'b1;
    pd_wr = 1'b1;
    pf = 16'hfffe;
    pf_wr = 1'b1;
    @(negedge i_clk);
    {pd_wr, pf_wr} = 2'b00;
    chk("strobe_pu", 1'b0, s_pu);
    chk("portf_pu", 16'hfffe, pf_en);
  endtask
  initial begin
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    t_reset();
    t_spaces();
    t_keep();
    t_pull();
    give_verdict();
  end
  initial begin
    #50000;
    n_mismatch++;
    give_verdict();
  end
endmodule
